// ==== design/admr_ctl_if.sv ====
// Purpose: Carries decoded register requests from the serial shifter.
// Assumes: Both ends run on ref_clk_i.
// Notes: rd_data answers combinationally from the register bank.
`timescale 1ns/1ps
`default_nettype none
interface admr_ctl_if;
  logic rd_req;
  logic wr_req;
  logic [6:0] index;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  modport ctl (output rd_req, output wr_req, output index, output wr_data,
    input rd_data);
  modport regs (input rd_req, input wr_req, input index, input wr_data,
    output rd_data);
endinterface
`default_nettype wire

// ==== design/admr_ctl_shifter.sv ====
// Purpose: Serial control port shifter, 16-bit command words MSB first.
// Assumes: Pins are asynchronous; sampled by two flip-flops first.
// Notes: Read data leaves on falling serial clock edges after bit 8.
`timescale 1ns/1ps
`default_nettype none
module admr_ctl_shifter
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ctl_sel_n_i,
  input wire logic ctl_clk_i,
  input wire logic ctl_data_i,
  output logic ctl_data_o,
  output logic ctl_data_oe_o,
  admr_ctl_if.ctl bus
);
  import admr_pkg::*;

  logic [2:0] sel_r;
  logic [2:0] sclk_r;
  logic [1:0] sdat_r;
  logic [15:0] shift_r;
  logic [4:0] cnt_r;
  logic [7:0] out_r;
  logic rw_r;
  logic rd_pend_r;
  admr_shift_state_type state_r;
  wire rise = sclk_r[1] & ~sclk_r[2];
  wire fall = ~sclk_r[1] & sclk_r[2];
  wire start = ~sel_r[1] & sel_r[2];
  wire stop = sel_r[1] & ~sel_r[2];
  wire [15:0] shift_nxt = {shift_r[14:0], sdat_r[1]};

  always_ff @(posedge ref_clk_i)
  begin
    sel_r <= {sel_r[1:0], ctl_sel_n_i};
    sclk_r <= {sclk_r[1:0], ctl_clk_i};
    sdat_r <= {sdat_r[0], ctl_data_i};
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      shift_r <= 16'h0000;
      cnt_r <= 5'h00;
      out_r <= 8'h00;
      rw_r <= 1'b0;
      rd_pend_r <= 1'b0;
      bus.rd_req <= 1'b0;
      bus.wr_req <= 1'b0;
      bus.index <= 7'h00;
      bus.wr_data <= 8'h00;
      ctl_data_o <= 1'b0;
      ctl_data_oe_o <= 1'b0;
    end
    else
    begin
      bus.rd_req <= 1'b0;
      bus.wr_req <= 1'b0;
      rd_pend_r <= bus.rd_req;
      if (rd_pend_r)
        out_r <= bus.rd_data;
      case (state_r)
        ST_IDLE:
        begin
          cnt_r <= 5'h00;
          if (start)
            state_r <= ST_HDR;
        end
        ST_HDR:
        begin
          if (rise)
          begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r + 5'h01 == CNT_HDR)
            begin
              // Top bit high asks for a read, low for a write.
              rw_r <= shift_nxt[CMD_RW_BIT - 8];
              bus.index <= shift_nxt[IDX_W-1:0];
              bus.rd_req <= shift_nxt[CMD_RW_BIT - 8];
              state_r <= ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (rise && cnt_r != CNT_FULL)
          begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_r + 5'h01;
          end
          if (fall && rw_r)
          begin
            ctl_data_oe_o <= 1'b1;
            ctl_data_o <= out_r[7];
            out_r <= {out_r[6:0], 1'b0};
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (stop)
      begin
        // A write counts only when all sixteen bits arrived.
        if (state_r == ST_DATA && !rw_r && cnt_r == CNT_FULL)
        begin
          bus.wr_req <= 1'b1;
          bus.wr_data <= shift_r[7:0];
        end
        state_r <= ST_IDLE;
        ctl_data_oe_o <= 1'b0;
      end
    end
  end
endmodule // admr_ctl_shifter
`default_nettype wire

// ==== design/admr_mode_regs.sv ====
// Purpose: Mode control register bank of a stereo audio DAC.
// Assumes: A host drives the serial control port; lrck_i is the frame clock.
// Notes: Attenuators ramp one code per interval toward their goal.
`timescale 1ns/1ps
`default_nettype none
module admr_mode_regs
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ctl_sel_n_i,
  input wire logic ctl_clk_i,
  input wire logic ctl_data_i,
  output logic ctl_data_o,
  output logic ctl_data_oe_o,
  input wire logic lrck_i,
  input wire logic dsd_mode_i,
  input wire logic left_zero_flag_i,
  input wire logic right_zero_flag_i,
  output logic [7:0] left_level_o,
  output logic [7:0] right_level_o,
  output logic left_mute_o,
  output logic right_mute_o,
  output logic [2:0] audio_format_select_o,
  output logic format_reserved_o,
  output logic [2:0] ext_filter_cfg_o,
  output logic deemph_enable_o,
  output logic [1:0] deemph_rate_select_o,
  output logic [1:0] fir_response_o,
  output logic soft_mute_o,
  output logic output_phase_invert_o,
  output logic [1:0] atten_step_rate_o,
  output logic dac_output_disable_o,
  output logic clock_out_halve_o,
  output logic clock_out_disable_o,
  output logic filter_rolloff_select_o,
  output logic zero_detect_mute_enable_o,
  output logic modulator_order_select_o,
  output logic system_soft_reset_o,
  output logic mode_regs_reset_o,
  output logic ext_filter_mode_o,
  output logic monaural_select_o,
  output logic monaural_select_channel_pick_o,
  output logic [1:0] oversample_rate_select_o
);
  import admr_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Codes below the minimum are full mute.
  function automatic logic is_mute_code(input logic [7:0] code);
    is_mute_code = (code < ATTEN_MIN_CODE);
  endfunction

  function automatic logic [2:0] step_mask(input logic [1:0] rate);
    case (rate)
      2'b00: step_mask = 3'h0;
      2'b01: step_mask = 3'h1;
      2'b10: step_mask = 3'h3;
      default: step_mask = 3'h7;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Serial port
  // ---------------------------------------------------------------
  admr_ctl_if bus ();

  admr_ctl_shifter u_shifter
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ctl_sel_n_i(ctl_sel_n_i),
    .ctl_clk_i(ctl_clk_i),
    .ctl_data_i(ctl_data_i),
    .ctl_data_o(ctl_data_o),
    .ctl_data_oe_o(ctl_data_oe_o),
    .bus(bus)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] lrck_r;
  logic [1:0] dsd_r;

  always_ff @(posedge ref_clk_i)
  begin
    lrck_r <= {lrck_r[1:0], lrck_i};
    dsd_r <= {dsd_r[0], dsd_mode_i};
  end

  wire lrck_rise = lrck_r[1] & ~lrck_r[2];
  wire dsd_mode = dsd_r[1];

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] code_r [NUM_CH];
  logic [7:0] target_r [NUM_CH];
  logic [7:0] applied_r [NUM_CH];
  logic [7:0] fmt_ctrl_r;
  logic [7:0] clk_filt_r;
  logic [7:0] sys_mod_r;
  logic [2:0] step_cnt_r;

  wire wr_fmt = bus.wr_req && bus.index == IDX_FMT_CTRL;
  wire wr_clk = bus.wr_req && bus.index == IDX_CLK_FILT;
  wire wr_sys = bus.wr_req && bus.index == IDX_SYS_MOD;
  wire load_en = fmt_ctrl_r[LOAD_BIT];
  wire soft_mute = fmt_ctrl_r[MUTE_BIT];
  wire [2:0] fmt = fmt_ctrl_r[FMT_MSB:FMT_LSB];
  wire [1:0] rate_sel = fmt_ctrl_r[RATE_MSB:RATE_LSB];
  wire deemph_bit = fmt_ctrl_r[DEEMPH_BIT];
  wire ext_mode = sys_mod_r[EXT_FILT_BIT];
  wire [1:0] step_rate = clk_filt_r[STEP_MSB:STEP_LSB];
  wire [2:0] mask = step_mask(step_rate);
  wire step_tick = lrck_rise && ((step_cnt_r & mask) == mask);
  wire [6:0] ch_index [NUM_CH];

  assign ch_index[0] = IDX_LEFT_ATTEN;
  assign ch_index[1] = IDX_RIGHT_ATTEN;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      fmt_ctrl_r <= FMT_CTRL_RST;
      clk_filt_r <= CLK_FILT_RST;
      sys_mod_r <= SYS_MOD_RST;
    end
    else
    begin
      if (wr_fmt)
        fmt_ctrl_r <= bus.wr_data;
      if (wr_clk)
        clk_filt_r <= bus.wr_data;
      if (wr_sys)
        sys_mod_r <= bus.wr_data;
    end
  end

  // The interval counter only advances on rising frame clock edges.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      step_cnt_r <= 3'h0;
    else if (lrck_rise)
      step_cnt_r <= step_cnt_r + 3'h1;
  end

  // ---------------------------------------------------------------
  // Per-channel attenuators
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      wire wr_code = bus.wr_req && bus.index == ch_index[ch];
      // Soft mute overrides the loaded target for both channels.
      wire [7:0] goal = soft_mute ? ATTEN_MUTE_CODE : target_r[ch];

      always_ff @(posedge ref_clk_i)
      begin
        if (!rst_n_i)
        begin
          code_r[ch] <= ATTEN_RST;
          target_r[ch] <= ATTEN_RST;
          applied_r[ch] <= ATTEN_RST;
        end
        else
        begin
          if (wr_code)
            code_r[ch] <= bus.wr_data;
          // The shared load gate decides whether a new code counts.
          if (wr_code && load_en)
            target_r[ch] <= bus.wr_data;
          // Stepping one code at a time avoids zipper noise on changes.
          if (step_tick && applied_r[ch] < goal)
            applied_r[ch] <= applied_r[ch] + 8'h01;
          else if (step_tick && applied_r[ch] > goal)
            applied_r[ch] <= applied_r[ch] - 8'h01;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------
  // The factory test bits read as zero and carry no meaning.
  wire [7:0] zero_status = {6'h00, right_zero_flag_i, left_zero_flag_i};

  always_comb
  begin
    case (bus.index)
      IDX_LEFT_ATTEN: bus.rd_data = code_r[0];
      IDX_RIGHT_ATTEN: bus.rd_data = code_r[1];
      IDX_FMT_CTRL: bus.rd_data = fmt_ctrl_r;
      IDX_CLK_FILT: bus.rd_data = clk_filt_r;
      IDX_SYS_MOD: bus.rd_data = sys_mod_r;
      IDX_ZERO_FLAG: bus.rd_data = zero_status;
      default: bus.rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Decoded mode outputs
  // ---------------------------------------------------------------
  wire fmt_rsv = fmt > FMT_LAST_VALID;
  wire [2:0] fmt_out = ext_mode ? 3'h0 : fmt;
  wire [2:0] ext_cfg = ext_mode ? fmt : 3'h0;
  // DSD mode relies on the host keeping the enable set.
  wire deemph_on = deemph_bit && !dsd_mode;
  wire [1:0] rate_out = deemph_on ? rate_sel : 2'b00;
  wire [1:0] fir_out = (dsd_mode && deemph_bit) ? rate_sel : 2'b00;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      left_level_o <= ATTEN_RST;
      right_level_o <= ATTEN_RST;
      left_mute_o <= 1'b0;
      right_mute_o <= 1'b0;
      audio_format_select_o <= 3'h0;
      format_reserved_o <= 1'b0;
      ext_filter_cfg_o <= 3'h0;
      deemph_enable_o <= 1'b0;
      deemph_rate_select_o <= 2'b00;
      fir_response_o <= 2'b00;
      soft_mute_o <= 1'b0;
    end
    else
    begin
      left_level_o <= applied_r[0];
      right_level_o <= applied_r[1];
      left_mute_o <= is_mute_code(applied_r[0]);
      right_mute_o <= is_mute_code(applied_r[1]);
      audio_format_select_o <= fmt_out;
      format_reserved_o <= fmt_rsv && !ext_mode;
      ext_filter_cfg_o <= ext_cfg;
      deemph_enable_o <= deemph_on;
      deemph_rate_select_o <= rate_out;
      fir_response_o <= fir_out;
      soft_mute_o <= soft_mute;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      output_phase_invert_o <= 1'b0;
      atten_step_rate_o <= 2'b00;
      dac_output_disable_o <= 1'b0;
      clock_out_halve_o <= 1'b0;
      clock_out_disable_o <= 1'b0;
      filter_rolloff_select_o <= 1'b0;
      zero_detect_mute_enable_o <= 1'b0;
      modulator_order_select_o <= 1'b0;
      system_soft_reset_o <= 1'b0;
      mode_regs_reset_o <= 1'b0;
      ext_filter_mode_o <= 1'b0;
      monaural_select_o <= 1'b0;
      monaural_select_channel_pick_o <= 1'b0;
      oversample_rate_select_o <= 2'b00;
    end
    else
    begin
      output_phase_invert_o <= clk_filt_r[INV_BIT];
      atten_step_rate_o <= step_rate;
      dac_output_disable_o <= clk_filt_r[OUT_DIS_BIT];
      clock_out_halve_o <= clk_filt_r[CLK_HALF_BIT];
      clock_out_disable_o <= clk_filt_r[CLK_DIS_BIT];
      filter_rolloff_select_o <= clk_filt_r[ROLLOFF_BIT];
      zero_detect_mute_enable_o <= clk_filt_r[ZERO_MUTE_BIT];
      modulator_order_select_o <= sys_mod_r[ORDER_BIT];
      system_soft_reset_o <= sys_mod_r[SYS_RST_BIT];
      mode_regs_reset_o <= sys_mod_r[REG_RST_BIT];
      ext_filter_mode_o <= ext_mode;
      monaural_select_o <= sys_mod_r[MONAURAL_SELECT_BIT];
      monaural_select_channel_pick_o <= sys_mod_r[CH_PICK_BIT];
      oversample_rate_select_o <= sys_mod_r[OSR_MSB:OSR_LSB];
    end
  end
endmodule // admr_mode_regs
`default_nettype wire

// ==== design/admr_pkg.sv ====
// Purpose: Shared constants for the audio DAC mode register bank.
// Assumes: 16-bit command words, register index in bits 14..8.
// Notes: Field positions are bit numbers inside the data byte.
package admr_pkg;
  localparam int CMD_W = 16;
  localparam int CMD_RW_BIT = 15;
  localparam int IDX_W = 7;
  localparam int NUM_CH = 2;
  localparam logic [4:0] CNT_HDR = 5'h08;
  localparam logic [4:0] CNT_FULL = 5'h10;
  // Register indices.
  localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
  localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
  localparam logic [6:0] IDX_FMT_CTRL = 7'h12;
  localparam logic [6:0] IDX_CLK_FILT = 7'h13;
  localparam logic [6:0] IDX_SYS_MOD = 7'h14;
  localparam logic [6:0] IDX_ZERO_FLAG = 7'h15;
  // Reset values and attenuator and format code limits.
  localparam logic [7:0] ATTEN_RST = 8'hff;
  localparam logic [7:0] FMT_CTRL_RST = 8'h00;
  localparam logic [7:0] CLK_FILT_RST = 8'h00;
  localparam logic [7:0] SYS_MOD_RST = 8'h00;
  localparam logic [7:0] ATTEN_MIN_CODE = 8'h0f;
  localparam logic [7:0] ATTEN_MUTE_CODE = 8'h00;
  localparam logic [2:0] FMT_LAST_VALID = 3'h5;
  // Format and de-emphasis control fields.
  localparam int LOAD_BIT = 7;
  localparam int FMT_MSB = 6;
  localparam int FMT_LSB = 4;
  localparam int RATE_MSB = 3;
  localparam int RATE_LSB = 2;
  localparam int DEEMPH_BIT = 1;
  localparam int MUTE_BIT = 0;
  // Output clock and filter control fields.
  localparam int INV_BIT = 7;
  localparam int STEP_MSB = 6;
  localparam int STEP_LSB = 5;
  localparam int OUT_DIS_BIT = 4;
  localparam int CLK_HALF_BIT = 3;
  localparam int CLK_DIS_BIT = 2;
  localparam int ROLLOFF_BIT = 1;
  localparam int ZERO_MUTE_BIT = 0;
  // System and modulator control fields.
  localparam int ORDER_BIT = 7;
  localparam int SYS_RST_BIT = 6;
  localparam int REG_RST_BIT = 5;
  localparam int EXT_FILT_BIT = 4;
  localparam int MONAURAL_SELECT_BIT = 3;
  localparam int CH_PICK_BIT = 2;
  localparam int OSR_MSB = 1;
  localparam int OSR_LSB = 0;
  // Zero flag status fields.
  localparam int ZFR_BIT = 1;
  localparam int ZFL_BIT = 0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_DATA = 2'b10
  } admr_shift_state_type;
endpackage

// ==== tb/admr_host_model.sv ====
// Purpose: Host controller model for the serial control port.
// Assumes: Each serial phase lasts six ref clocks, well above the sync minimum.
// Notes: Read bits are taken just before the next rising serial edge.
`timescale 1ns/1ps
`default_nettype none
module admr_host_model
(
  input wire logic ref_clk_i,
  output logic sel_n_o,
  output logic sclk_o,
  output logic sdata_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  localparam int PH = 6;
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    sdata_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge ref_clk_i);
    sel_n_o = 1'b0;
    repeat (PH) @(negedge ref_clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      sdata_o = w[i];
      repeat (PH) @(negedge ref_clk_i);
      // An undriven answer is made unknown so that it never matches.
      if (i < 8) rd[i] = (sdo_oe_i === 1'b1) ? sdo_i : 1'bx;
      sclk_o = 1'b1;
      repeat (PH) @(negedge ref_clk_i);
      sclk_o = 1'b0;
    end
    repeat (PH) @(negedge ref_clk_i);
    sel_n_o = 1'b1;
    sdata_o = ~sdata_o;
    repeat (2 * PH) @(negedge ref_clk_i);
  endtask
endmodule // admr_host_model
`default_nettype wire

// ==== tb/admr_mode_regs_asserts.sv ====
// Purpose: Concurrent checks on the mode register bank's output relations.
// Assumes: All outputs are registered on ref_clk_i and lag the register state they decode by one clock.
// Notes: Attached by bind from the bench; it watches design outputs plus the reset and select inputs.
`timescale 1ns/1ps
`default_nettype none
module admr_mode_regs_asserts
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ctl_sel_n_i,
  input wire logic ctl_data_oe_o,
  input wire logic [7:0] left_level_o,
  input wire logic [7:0] right_level_o,
  input wire logic left_mute_o,
  input wire logic right_mute_o,
  input wire logic [2:0] audio_format_select_o,
  input wire logic format_reserved_o,
  input wire logic [2:0] ext_filter_cfg_o,
  input wire logic ext_filter_mode_o,
  input wire logic deemph_enable_o,
  input wire logic [1:0] deemph_rate_select_o,
  input wire logic [1:0] fir_response_o,
  input wire logic soft_mute_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Attenuator relations
  // ----------------------------------------------------------------
  chk_left_mute_code: assert property (left_mute_o == (left_level_o < 8'h0f))
    else $error("left mute does not match applied code");
  chk_right_mute_code: assert property (right_mute_o == (right_level_o < 8'h0f))
    else $error("right mute does not match applied code");
  // A jump of more than one code would be an audible click.
  chk_left_step_one: assert property ((left_level_o == $past(left_level_o)) ||
    (left_level_o == $past(left_level_o) + 8'h01) || (left_level_o == $past(left_level_o) - 8'h01))
    else $error("left level moved by more than one step");
  chk_right_step_one: assert property ((right_level_o == $past(right_level_o)) ||
    (right_level_o == $past(right_level_o) + 8'h01) || (right_level_o == $past(right_level_o) - 8'h01))
    else $error("right level moved by more than one step");
  chk_soft_mute_down: assert property (soft_mute_o && $past(soft_mute_o, 2) |->
    (left_level_o <= $past(left_level_o)) && (right_level_o <= $past(right_level_o)))
    else $error("level rose while soft mute held");
  // ----------------------------------------------------------------
  // Format, de-emphasis and port relations
  // ----------------------------------------------------------------
  chk_ext_fmt_zero: assert property (ext_filter_mode_o |-> audio_format_select_o == 3'h0)
    else $error("format output active in external filter mode");
  chk_ext_cfg_idle: assert property (!ext_filter_mode_o |-> ext_filter_cfg_o == 3'h0)
    else $error("external filter config active outside its mode");
  chk_fmt_reserved: assert property (format_reserved_o == (audio_format_select_o[2:1] == 2'b11))
    else $error("reserved format flag wrong");
  chk_rate_gated: assert property (!deemph_enable_o |-> deemph_rate_select_o == 2'b00)
    else $error("rate selected while de-emphasis off");
  chk_fir_excl: assert property (deemph_enable_o |-> fir_response_o == 2'b00)
    else $error("filter response selected outside DSD use");
  chk_oe_idle: assert property (ctl_sel_n_i [*8] |-> !ctl_data_oe_o)
    else $error("read data driven with select high");
endmodule // admr_mode_regs_asserts
`default_nettype wire

// ==== tb/admr_mode_regs_bench.sv ====
// Purpose: Self-checking bench for the mode register bank.
// Assumes: One frame clock rise every eight ref clocks paces the attenuators.
// Notes: Ramps are awaited with a bounded loop on the applied levels.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s expected %h seen %h", nm, (e), (g)); end end
module admr_mode_regs_bench;
  import admr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic lrck_i = 1'b0;
  logic dsd_mode_i = 1'b0;
  logic left_zero_flag_i = 1'b0;
  logic right_zero_flag_i = 1'b0;
  logic ctl_sel_n_i, ctl_clk_i, ctl_data_i, ctl_data_o, ctl_data_oe_o;
  logic [7:0] left_level_o, right_level_o, rd;
  logic left_mute_o, right_mute_o, format_reserved_o, deemph_enable_o, soft_mute_o;
  logic [2:0] audio_format_select_o, ext_filter_cfg_o;
  logic [1:0] deemph_rate_select_o, fir_response_o, atten_step_rate_o, oversample_rate_select_o;
  logic output_phase_invert_o, dac_output_disable_o, clock_out_halve_o, clock_out_disable_o;
  logic filter_rolloff_select_o, zero_detect_mute_enable_o, modulator_order_select_o;
  logic system_soft_reset_o, mode_regs_reset_o, ext_filter_mode_o, monaural_select_o;
  logic monaural_select_channel_pick_o;
  logic [4:0] dm_seen;
  logic [7:0] clk_seen, sys_seen;
  logic [23:0] rst_seen;
  int err_count = 0;
  int checked = 0;
  assign dm_seen = {deemph_enable_o, deemph_rate_select_o, fir_response_o};
  assign clk_seen = {output_phase_invert_o, atten_step_rate_o, dac_output_disable_o,
    clock_out_halve_o, clock_out_disable_o, filter_rolloff_select_o, zero_detect_mute_enable_o};
  assign sys_seen = {modulator_order_select_o, system_soft_reset_o, mode_regs_reset_o,
    ext_filter_mode_o, monaural_select_o, monaural_select_channel_pick_o, oversample_rate_select_o};
  assign rst_seen = {left_level_o, right_level_o, soft_mute_o, deemph_enable_o,
    audio_format_select_o, atten_step_rate_o, ext_filter_mode_o};
  admr_mode_regs dut (.*);
  admr_host_model h (.ref_clk_i(ref_clk_i), .sel_n_o(ctl_sel_n_i), .sclk_o(ctl_clk_i),
    .sdata_o(ctl_data_i), .sdo_i(ctl_data_o), .sdo_oe_i(ctl_data_oe_o));
  always #10 ref_clk_i = ~ref_clk_i;
  always
  begin
    repeat (4) @(negedge ref_clk_i);
    lrck_i = ~lrck_i;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    h.xfer({1'b0, idx, d}, unused);
  endtask
  task automatic rdr(input logic [6:0] idx);
    h.xfer({1'b1, idx, 8'h00}, rd);
  endtask
  task automatic settle(input logic [7:0] l, input logic [7:0] r);
    for (int k = 0; k < 3000 && !(left_level_o === l && right_level_o === r); k++)
      @(negedge ref_clk_i);
    `CHK("left_level", l, left_level_o)
    `CHK("right_level", r, right_level_o)
  endtask
  function automatic logic [4:0] exp_dm(logic dsd, logic en, logic [1:0] r);
    logic on;
    on = en & ~dsd;
    return {on, on ? r : 2'b00, (dsd & en) ? r : 2'b00};
  endfunction
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    err_count++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic [2:0] f;
    int n;
    d = 8'($urandom(32'hcdf9e39d));
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    `CHK("rst_level", {ATTEN_RST, ATTEN_RST}, {left_level_o, right_level_o})
    `CHK("rst_ctrl", 5'h00, {deemph_enable_o, soft_mute_o, audio_format_select_o})
    for (int i = 0; i < 5; i++)
    begin
      rdr(IDX_LEFT_ATTEN + 7'(i));
      `CHK("reg_reset", (i < 2) ? ATTEN_RST : FMT_CTRL_RST, rd)
    end
    wr(IDX_LEFT_ATTEN, 8'h80);
    rdr(IDX_LEFT_ATTEN);
    `CHK("left_stored", 8'h80, rd)
    repeat (400) @(negedge ref_clk_i);
    `CHK("left_held", ATTEN_RST, left_level_o)
    wr(IDX_FMT_CTRL, 8'h80);
    wr(IDX_LEFT_ATTEN, ATTEN_MIN_CODE);
    wr(IDX_RIGHT_ATTEN, ATTEN_MIN_CODE - 8'h01);
    settle(ATTEN_MIN_CODE, ATTEN_MIN_CODE - 8'h01);
    `CHK("mute_edge", 2'b01, {left_mute_o, right_mute_o})
    wr(IDX_FMT_CTRL, 8'h81);
    settle(8'h00, 8'h00);
    `CHK("soft_mute", 3'b111, {soft_mute_o, left_mute_o, right_mute_o})
    wr(IDX_FMT_CTRL, 8'h80);
    settle(ATTEN_MIN_CODE, ATTEN_MIN_CODE - 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      f = 3'(i);
      wr(IDX_FMT_CTRL, {1'b1, f, 4'h0});
      `CHK("fmt", {f, f[2:1] == 2'b11}, {audio_format_select_o, format_reserved_o})
    end
    f = 3'($urandom);
    wr(IDX_SYS_MOD, 8'h10);
    wr(IDX_FMT_CTRL, {1'b1, f, 4'h0});
    `CHK("ext_fmt", {f, 4'h0}, {ext_filter_cfg_o, audio_format_select_o, format_reserved_o})
    wr(IDX_SYS_MOD, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      // The host keeps de-emphasis enabled whenever DSD mode is on.
      dsd_mode_i = (i >= 8);
      wr(IDX_FMT_CTRL, {4'h8, 2'(i), i >= 4, 1'b0});
      `CHK("deemph", exp_dm(i >= 8, i >= 4, 2'(i)), dm_seen)
    end
    dsd_mode_i = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {right_zero_flag_i, left_zero_flag_i} = 2'(i);
      wr(IDX_ZERO_FLAG, 8'hff);
      rdr(IDX_ZERO_FLAG);
      `CHK("zero_flags", 2'(i), rd[1:0])
    end
    rdr(7'h30);
    `CHK("unmapped", 8'h00, rd)
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      wr(IDX_CLK_FILT, d);
      rdr(IDX_CLK_FILT);
      `CHK("clk_filt", d, rd)
      `CHK("clk_fields", d, clk_seen)
      d = 8'($urandom) & 8'h9f;
      wr(IDX_SYS_MOD, d);
      rdr(IDX_SYS_MOD);
      `CHK("sys_mod", d, rd)
      `CHK("sys_fields", d, sys_seen)
    end
    // A second reset in mid-run must restore every register and level.
    rst_n_i = 1'b0;
    repeat (10) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge ref_clk_i);
    `CHK("rerst_out", {ATTEN_RST, ATTEN_RST, 8'h00}, rst_seen)
    for (int i = 0; i < 5; i++)
    begin
      rdr(IDX_LEFT_ATTEN + 7'(i));
      `CHK("rerst_reg", (i < 2) ? ATTEN_RST : FMT_CTRL_RST, rd)
    end
    // The slowest step rate moves the level once every eight frames.
    wr(IDX_CLK_FILT, 8'h60);
    wr(IDX_FMT_CTRL, 8'h80);
    wr(IDX_LEFT_ATTEN, 8'hfb);
    n = 0;
    while (n < 1000 && left_level_o !== 8'hfb)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("slow_ramp", 1'b1, n > 150 && n < 300)
    report_and_stop();
  end
endmodule // admr_mode_regs_bench
bind admr_mode_regs admr_mode_regs_asserts chk (.*);
`default_nettype wire
